/* File: common/ucb_map.svh */
/*
 Offsets, reset values, field positions, codes and timing figures
 of the bridge configuration register bank.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef UCB_MAP_SVH
`define UCB_MAP_SVH
`define UCB_ADDR_BAUD_LO 8'h00
`define UCB_ADDR_BAUD_HI 8'h01
`define UCB_ADDR_CONF_LO 8'h02
`define UCB_ADDR_CONF_HI 8'h03
`define UCB_ADDR_LEVEL 8'h04
`define UCB_ADDR_RSVD 8'h05
`define UCB_ADDR_OWN 8'h06
`define UCB_ADDR_SCL_LO 8'h07
`define UCB_ADDR_SCL_HI 8'h08
`define UCB_ADDR_TMO 8'h09
`define UCB_ADDR_RESULT 8'h0A
`define UCB_RST_BAUD_LO 8'hF0
`define UCB_RST_BAUD_HI 8'h02
`define UCB_RST_CONF 8'h55
`define UCB_RST_LEVEL 8'h0F
`define UCB_RST_OWN 8'h26
`define UCB_RST_SCL 8'h13
`define UCB_RST_TMO 8'h66
`define UCB_RST_RESULT 4'h0
`define UCB_ZERO8 8'h00
`define UCB_MODE_QUASI 2'h0
`define UCB_MODE_INPUT 2'h1
`define UCB_MODE_PUSH 2'h2
`define UCB_MODE_OPEN 2'h3
`define UCB_RES_TIMEOUT 4'h8
`define UCB_RESULT_UPPER 4'hF
`define UCB_BAUD_BASE 17'h00010
`define UCB_SCL_MIN_SUM 9'h00A
`define UCB_SCL_SAFE_HALF 8'h05
`define UCB_TMO_EN_BIT 0
`define UCB_TMO_VAL_MSB 7
`define UCB_TMO_VAL_LSB 1
`define UCB_NUM_PINS 8
`define UCB_PRE_W 17
`define UCB_CLK_HZ 20000000
`define UCB_TMO_UNIT_NUM 256
`define UCB_TMO_UNIT_DEN 57600
`define UCB_TMO_TICK_CYCLES (`UCB_CLK_HZ / (`UCB_TMO_UNIT_DEN / `UCB_TMO_UNIT_NUM))
`endif

/* File: common/ucb_pkg.sv */
/*
 Types of the bridge configuration register bank.
 Assumes ucb_map.svh is on the include path.
*/
`include "ucb_map.svh"
package ucb_pkg;
    typedef logic [1:0] ucb_pin_mode_type;
    typedef struct packed {
        logic [`UCB_NUM_PINS-1:0] out;
        logic [`UCB_NUM_PINS-1:0] oe;
        logic [`UCB_NUM_PINS-1:0] pull;
    } ucb_pad_type;
    typedef struct packed {
        logic [`UCB_PRE_W-1:0] pre;
        logic [6:0] left;
        logic expire;
    } ucb_tmo_type;
    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] baud_lo;
        logic [7:0] baud_hi;
        logic [16:0] baud_eff;
        logic [7:0] conf_lo;
        logic [7:0] conf_hi;
        logic [7:0] latch;
        logic [7:0] own_addr;
        logic [7:0] scl_lo;
        logic [7:0] scl_hi;
        logic [7:0] scl_lo_eff;
        logic [7:0] scl_hi_eff;
        logic [7:0] tmo;
        logic [3:0] result;
        logic scl_s1;
        logic scl_s2;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
    } ucb_regs_type;
endpackage

/* File: rtl/ucb_cfg_regs.sv */
/*
 Configuration and status register bank of the UART-to-bus bridge.
 Holds the baud divisor, pin modes and levels, own address, SCL
 timing, SCL-stuck time-out and the last transfer result.
 Assumes the command parser issues one-cycle REG_WR / REG_RD strobes
 on REF_CLK, and that the bus master drives BUS_* and FRAME_* on the
 same clock. GPIO_IN and SCL_IN are raw pins.
*/
`timescale 1ns/1ps
`include "ucb_map.svh"
module ucb_cfg_regs
    import ucb_pkg::*;
#(
    parameter int TMO_TICK_CYCLES = `UCB_TMO_TICK_CYCLES
)
(
    input wire logic REF_CLK, // 20 MHz reference
    input wire logic RESETN, // Asynchronous reset, low active
    input wire logic REG_WR, // Register write strobe
    input wire logic REG_RD, // Register read strobe
    input wire logic [7:0] REG_ADDR, // Register address
    input wire logic [7:0] REG_WDATA, // Write data
    output logic [7:0] REG_RDATA, // Read data
    output logic REG_RVALID, // Read data valid pulse
    input wire logic [7:0] GPIO_IN, // Pin levels from pads
    output logic [7:0] GPIO_OUT, // Pin output value
    output logic [7:0] GPIO_OE, // Pin strong drive enable
    output logic [7:0] GPIO_PULLUP, // Pin weak pull-up enable
    input wire logic SCL_IN, // SCL wire level
    input wire logic BUS_ACTIVE, // Bus master running
    input wire logic BUS_STEP, // Bus master state change
    input wire logic FRAME_DONE, // Frame finished pulse
    input wire logic [3:0] FRAME_CODE, // Frame outcome code
    output logic [16:0] BAUD_DIVISOR, // Active UART rate divisor
    output logic [7:0] OWN_ADDRESS, // Own bus address
    output logic [7:0] SCL_HIGH_COUNT, // SCL high period count
    output logic [7:0] SCL_LOW_COUNT, // SCL low period count
    output logic MASTER_RESET // Time-out reset pulse
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    ucb_regs_type st_ff;
    ucb_regs_type nxt_st;
    logic [7:0] rd_val;
    logic [8:0] scl_sum;
    logic tmo_expire;
    ucb_pad_type pad;

    // Release is synchronous so no flop sees a partial reset edge
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always_comb begin
        nxt_st = st_ff;
        rd_val = `UCB_ZERO8;
        scl_sum = {1'b0, st_ff.scl_hi} + {1'b0, st_ff.scl_lo};
        nxt_st.rvalid = 1'b0;
        nxt_st.scl_s1 = SCL_IN;
        nxt_st.scl_s2 = st_ff.scl_s1;
        nxt_st.pin_s1 = GPIO_IN;
        nxt_st.pin_s2 = st_ff.pin_s1;
        if (REG_WR) begin
            case (REG_ADDR)
                `UCB_ADDR_BAUD_LO: begin
                    // Held back until the high byte arrives
                    nxt_st.baud_lo = REG_WDATA;
                end
                `UCB_ADDR_BAUD_HI: begin
                    nxt_st.baud_hi = REG_WDATA;
                    nxt_st.baud_eff = `UCB_BAUD_BASE +
                        {1'b0, REG_WDATA, st_ff.baud_lo};
                end
                `UCB_ADDR_CONF_LO: begin
                    nxt_st.conf_lo = REG_WDATA;
                end
                `UCB_ADDR_CONF_HI: begin
                    nxt_st.conf_hi = REG_WDATA;
                end
                `UCB_ADDR_LEVEL: begin
                    nxt_st.latch = REG_WDATA;
                end
                `UCB_ADDR_OWN: begin
                    // Bit 0 kept as written; software is to leave it 0
                    nxt_st.own_addr = REG_WDATA;
                end
                `UCB_ADDR_SCL_LO: begin
                    nxt_st.scl_lo = REG_WDATA;
                end
                `UCB_ADDR_SCL_HI: begin
                    nxt_st.scl_hi = REG_WDATA;
                end
                `UCB_ADDR_TMO: begin
                    nxt_st.tmo = REG_WDATA;
                end
                default: begin
                    // Reserved, result and unmapped slots ignore writes
                    nxt_st = nxt_st;
                end
            endcase
        end
        case (REG_ADDR)
            `UCB_ADDR_BAUD_LO: rd_val = st_ff.baud_lo;
            `UCB_ADDR_BAUD_HI: rd_val = st_ff.baud_hi;
            `UCB_ADDR_CONF_LO: rd_val = st_ff.conf_lo;
            `UCB_ADDR_CONF_HI: rd_val = st_ff.conf_hi;
            `UCB_ADDR_LEVEL: rd_val = st_ff.pin_s2;
            `UCB_ADDR_OWN: rd_val = st_ff.own_addr;
            `UCB_ADDR_SCL_LO: rd_val = st_ff.scl_lo;
            `UCB_ADDR_SCL_HI: rd_val = st_ff.scl_hi;
            `UCB_ADDR_TMO: rd_val = st_ff.tmo;
            `UCB_ADDR_RESULT: begin
                rd_val = {`UCB_RESULT_UPPER, st_ff.result};
            end
            default: rd_val = `UCB_ZERO8;
        endcase
        if (REG_RD) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_val;
        end
        // A sum under the floor would overrun the bus rate; fall back
        if (scl_sum < `UCB_SCL_MIN_SUM) begin
            nxt_st.scl_hi_eff = `UCB_SCL_SAFE_HALF;
            nxt_st.scl_lo_eff = `UCB_SCL_SAFE_HALF;
        end else begin
            nxt_st.scl_hi_eff = st_ff.scl_hi;
            nxt_st.scl_lo_eff = st_ff.scl_lo;
        end
        // A time-out in the same cycle as a frame end outranks it
        if (tmo_expire) begin
            nxt_st.result = `UCB_RES_TIMEOUT;
        end else if (FRAME_DONE) begin
            nxt_st.result = FRAME_CODE;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.baud_lo <= `UCB_RST_BAUD_LO;
            st_ff.baud_hi <= `UCB_RST_BAUD_HI;
            st_ff.baud_eff <= `UCB_BAUD_BASE +
                {1'b0, `UCB_RST_BAUD_HI, `UCB_RST_BAUD_LO};
            st_ff.conf_lo <= `UCB_RST_CONF;
            st_ff.conf_hi <= `UCB_RST_CONF;
            st_ff.latch <= `UCB_RST_LEVEL;
            st_ff.own_addr <= `UCB_RST_OWN;
            st_ff.scl_lo <= `UCB_RST_SCL;
            st_ff.scl_hi <= `UCB_RST_SCL;
            st_ff.scl_lo_eff <= `UCB_RST_SCL;
            st_ff.scl_hi_eff <= `UCB_RST_SCL;
            st_ff.tmo <= `UCB_RST_TMO;
            st_ff.result <= `UCB_RST_RESULT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ucb_pad_drive u_pad (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .mode({st_ff.conf_hi, st_ff.conf_lo}),
        .latch(st_ff.latch),
        .pad(pad)
    );

    ucb_scl_watch #(
        .TICK_CYCLES(TMO_TICK_CYCLES)
    ) u_watch (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .enable(st_ff.tmo[`UCB_TMO_EN_BIT]),
        .value(st_ff.tmo[`UCB_TMO_VAL_MSB:`UCB_TMO_VAL_LSB]),
        .scl_low(!st_ff.scl_s2),
        .bus_active(BUS_ACTIVE),
        .bus_step(BUS_STEP),
        .expire(tmo_expire)
    );

    assign REG_RDATA = st_ff.rdata;
    assign REG_RVALID = st_ff.rvalid;
    assign GPIO_OUT = pad.out;
    assign GPIO_OE = pad.oe;
    assign GPIO_PULLUP = pad.pull;
    assign BAUD_DIVISOR = st_ff.baud_eff;
    assign OWN_ADDRESS = st_ff.own_addr;
    assign SCL_HIGH_COUNT = st_ff.scl_hi_eff;
    assign SCL_LOW_COUNT = st_ff.scl_lo_eff;
    assign MASTER_RESET = tmo_expire;

    baud_apply_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_BAUD_HI |=>
        BAUD_DIVISOR == `UCB_BAUD_BASE +
        {1'b0, $past(REG_WDATA), $past(st_ff.baud_lo)})
        else $error("divisor not applied on high byte write");
    baud_hold_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_BAUD_LO |=> $stable(BAUD_DIVISOR))
        else $error("divisor changed on low byte write");
    level_read_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_RD && REG_ADDR == `UCB_ADDR_LEVEL |=>
        REG_RVALID && REG_RDATA == $past(st_ff.pin_s2))
        else $error("level read not the sampled pins");
    latch_load_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_LEVEL |=>
        st_ff.latch == $past(REG_WDATA))
        else $error("latch not loaded");
    result_upper_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_RD && REG_ADDR == `UCB_ADDR_RESULT |=>
        REG_RDATA == {`UCB_RESULT_UPPER, $past(st_ff.result)})
        else $error("result read wrong");
    rsvd_zero_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_RD && REG_ADDR == `UCB_ADDR_RSVD |=> REG_RDATA == `UCB_ZERO8)
        else $error("reserved slot reads nonzero");
    timeout_code_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        MASTER_RESET |=> st_ff.result == `UCB_RES_TIMEOUT)
        else $error("time-out not recorded");
    scl_floor_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        ##1 ({1'b0, SCL_HIGH_COUNT} + {1'b0, SCL_LOW_COUNT})
        >= `UCB_SCL_MIN_SUM)
        else $error("SCL period under the floor");
    rd_valid_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_RD |=> REG_RVALID)
        else $error("read strobe without valid data");
    rd_idle_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        !REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
        else $error("read data moved without a read");
    own_load_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_OWN |=>
        OWN_ADDRESS == $past(REG_WDATA))
        else $error("own address not loaded");
    conf_load_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_CONF_HI |=>
        st_ff.conf_hi == $past(REG_WDATA))
        else $error("high pin group modes not loaded");
    tmo_load_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_TMO |=>
        st_ff.tmo == $past(REG_WDATA))
        else $error("time-out register not loaded");
    lo_store_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        REG_WR && REG_ADDR == `UCB_ADDR_BAUD_LO |=>
        st_ff.baud_lo == $past(REG_WDATA))
        else $error("low divisor byte not stored");
    baud_only_hi_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        !(REG_WR && REG_ADDR == `UCB_ADDR_BAUD_HI) |=>
        $stable(BAUD_DIVISOR))
        else $error("divisor changed without high byte write");
    frame_code_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        FRAME_DONE && !MASTER_RESET |=>
        st_ff.result == $past(FRAME_CODE))
        else $error("frame outcome not recorded");
    result_ro_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        !FRAME_DONE && !MASTER_RESET |=> $stable(st_ff.result))
        else $error("status changed without an event");
    scl_pass_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        scl_sum >= `UCB_SCL_MIN_SUM |=>
        SCL_HIGH_COUNT == $past(st_ff.scl_hi) &&
        SCL_LOW_COUNT == $past(st_ff.scl_lo))
        else $error("legal SCL counts not passed on");
    pin_sync_a: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        $past(rst_n, 2) |-> st_ff.pin_s2 == $past(GPIO_IN, 2))
        else $error("pin levels not two stages late");
endmodule

/* File: rtl/ucb_pad_drive.sv */
/*
 Per-pin driver control for the eight general-purpose pins.
 Assumes mode and latch come from the register bank on the same clock;
 the pad itself resolves out, oe and the weak pull-up.
*/
`timescale 1ns/1ps
`include "ucb_map.svh"
module ucb_pad_drive
    import ucb_pkg::*;
(
    input wire logic clk, // Reference clock
    input wire logic rst_n, // Synchronised reset, low active
    input wire logic [15:0] mode, // Two mode bits per pin
    input wire logic [7:0] latch, // Output latch per pin
    output ucb_pad_type pad // Registered drive controls
);
    ucb_pad_type st_ff;
    ucb_pad_type nxt_st;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [7:0] d_pull;

    genvar i;
    generate
        for (i = 0; i < `UCB_NUM_PINS; i++) begin : g_pin
            ucb_pin_mode_type m;
            assign m = mode[2*i+1:2*i];
            // Quasi: strong low, weak high only
            // Input-only: never driven
            // Push-pull: strong both ways
            // Open-drain: low only, never high
            assign d_oe[i] = (m == `UCB_MODE_PUSH) ||
                             ((m != `UCB_MODE_INPUT) && !latch[i]);
            assign d_out[i] = (m == `UCB_MODE_PUSH) && latch[i];
            assign d_pull[i] = (m == `UCB_MODE_QUASI) && latch[i];
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        nxt_st.out = d_out;
        nxt_st.oe = d_oe;
        nxt_st.pull = d_pull;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pad = st_ff;

    input_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode[1:0] == `UCB_MODE_INPUT |=> !pad.oe[0] && !pad.pull[0])
        else $error("input-only pin is driven");
    open_high_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode[15:14] == `UCB_MODE_OPEN |=> !pad.out[7] && !pad.pull[7]
        && (pad.oe[7] == !$past(latch[7])))
        else $error("open-drain pin drives high or misses low");
    push_both_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode[5:4] == `UCB_MODE_PUSH |=> pad.oe[2]
        && (pad.out[2] == $past(latch[2])))
        else $error("push-pull pin not following latch");
    quasi_weak_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode[7:6] == `UCB_MODE_QUASI |=> (pad.oe[3] == !$past(latch[3]))
        && (pad.pull[3] == $past(latch[3])) && !pad.out[3])
        else $error("quasi pin drive wrong");
endmodule

/* File: rtl/ucb_scl_watch.sv */
/*
 SCL-stuck-low watchdog: counts prescaled ticks while SCL is low and
 raises a one-cycle expire pulse that resets the bus master.
 Assumes scl_low is already synchronised and bus_step comes from the
 master on the same clock.
*/
`timescale 1ns/1ps
`include "ucb_map.svh"
module ucb_scl_watch
    import ucb_pkg::*;
#(
    parameter int TICK_CYCLES = `UCB_TMO_TICK_CYCLES
)
(
    input wire logic clk, // Reference clock
    input wire logic rst_n, // Synchronised reset, low active
    input wire logic enable, // Watchdog enable
    input wire logic [6:0] value, // Tick count allowed
    input wire logic scl_low, // Synchronised SCL is low
    input wire logic bus_active, // Master is running
    input wire logic bus_step, // Master changed state
    output logic expire // One-cycle time-out pulse
);
    localparam logic [`UCB_PRE_W-1:0] LAST = `UCB_PRE_W'(TICK_CYCLES - 1);
    ucb_tmo_type st_ff;
    ucb_tmo_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.expire = 1'b0;
        if (!enable || !bus_active || !scl_low || bus_step) begin
            nxt_st.pre = '0;
            nxt_st.left = value;
        end else if (st_ff.pre == LAST) begin
            // Coarse unit of 256/57600 s; accuracy is not a goal
            nxt_st.pre = '0;
            if (st_ff.left <= 7'h01) begin
                nxt_st.expire = 1'b1;
                nxt_st.left = value;
            end else begin
                nxt_st.left = st_ff.left - 7'h01;
            end
        end else begin
            nxt_st.pre = st_ff.pre + `UCB_PRE_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expire = st_ff.expire;

    tmo_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !expire)
        else $error("time-out fired while disabled");
    step_reload_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        bus_step |=> st_ff.left == $past(value) && st_ff.pre == '0)
        else $error("counter not reloaded on bus step");
endmodule

/* File: verification/tb.sv */
/*
 Self-checking bench of the configuration register bank.
 Assumes the package, the rtl files and the host model compile first.
*/
`timescale 1ns/1ps
module tb;
    import ucb_pkg::*;
    localparam int TICK = 4;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, mrst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] ext_lvl = 8'h00;
    logic [7:0] gpio_out, gpio_oe, gpio_pu, own, sclh, scll;
    logic [16:0] baud;
    logic scl = 1'b1;
    logic act = 1'b0;
    logic step = 1'b0;
    logic fdone = 1'b0;
    logic [3:0] fcode = 4'h0;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;

    always #25 ref_clk = ~ref_clk;

    ucb_host_model host (.clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Strong drive wins; otherwise the external device sets the level
    ucb_cfg_regs #(.TMO_TICK_CYCLES(TICK)) uut (.REF_CLK(ref_clk),
        .RESETN(resetn), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .GPIO_IN((gpio_oe & gpio_out) | (~gpio_oe & ext_lvl)),
        .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .GPIO_PULLUP(gpio_pu),
        .SCL_IN(scl), .BUS_ACTIVE(act), .BUS_STEP(step),
        .FRAME_DONE(fdone), .FRAME_CODE(fcode), .BAUD_DIVISOR(baud),
        .OWN_ADDRESS(own), .SCL_HIGH_COUNT(sclh), .SCL_LOW_COUNT(scll),
        .MASTER_RESET(mrst));

    task automatic fail(input string msg);
        n_mismatch++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic chk_byte(input logic [7:0] got, exp, input string what);
        checks_done++;
        if (got !== exp)
            fail($sformatf("%s got %h want %h", what, got, exp));
    endtask
    task automatic chk_word(input logic [16:0] got, exp, input string what);
        checks_done++;
        if (got !== exp)
            fail($sformatf("%s got %h want %h", what, got, exp));
    endtask
    task automatic chk_bit(input logic got, exp, input string what);
        checks_done++;
        if (got !== exp)
            fail($sformatf("%s got %b want %b", what, got, exp));
    endtask
    task automatic rd_chk(input logic [7:0] addr, exp, input string what);
        logic [7:0] d;
        logic ok;
        host.rd(addr, d, ok);
        chk_bit(ok, 1'b1, "read valid");
        chk_byte(d, exp, what);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic t_reset();
        logic [7:0] def [0:10] = '{8'hF0, 8'h02, 8'h55, 8'h55, 8'h00,
            8'h00, 8'h26, 8'h13, 8'h13, 8'h66, 8'hF0};
        for (int a = 0; a < 11; a++)
            rd_chk(8'(a), def[a], "reset value");
        rd_chk(8'h0B, 8'h00, "unmapped");
        chk_word(baud, 17'h00300, "reset baud");
        chk_byte(own, 8'h26, "reset own");
        chk_byte(sclh, 8'h13, "reset scl");
        chk_byte(gpio_oe | gpio_pu, 8'h00, "input only");
    endtask

    task automatic t_level();
        ext_lvl = 8'hA5;
        host.wr(8'h02, 8'hAA);
        host.wr(8'h03, 8'hAA);
        wait_cyc(2);
        chk_byte(gpio_out, 8'h0F, "latch default");
        host.wr(8'h04, 8'h3C);
        wait_cyc(4);
        chk_byte(gpio_out, 8'h3C, "latch write");
        rd_chk(8'h04, 8'h3C, "driven level");
        host.wr(8'h02, 8'h55);
        host.wr(8'h03, 8'h55);
        wait_cyc(4);
        rd_chk(8'h04, 8'hA5, "input level");
    endtask

    task automatic t_modes();
        logic [7:0] lt = 8'h5A;
        logic [7:0] e_oe, e_out, e_pu;
        host.wr(8'h04, lt);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h02, {4{2'(m)}});
            host.wr(8'h03, {4{2'(m)}});
            wait_cyc(2);
            e_oe = (m == 1) ? 8'h00 : (m == 2) ? 8'hFF : ~lt;
            e_out = (m == 2) ? lt : 8'h00;
            e_pu = (m == 0) ? lt : 8'h00;
            chk_byte(gpio_oe, e_oe, "mode oe");
            chk_byte(gpio_out, e_out, "mode out");
            chk_byte(gpio_pu, e_pu, "mode pull");
        end
    endtask

    task automatic t_fields();
        logic [15:0] cf;
        for (int n = 0; n < 8; n++) begin
            cf = (16'h5555 & ~(16'h0003 << (2 * n))) | (16'h0002 << (2 * n));
            host.wr(8'h02, cf[7:0]);
            host.wr(8'h03, cf[15:8]);
            wait_cyc(2);
            chk_byte(gpio_oe, 8'h01 << n, "pin field");
        end
    endtask

    task automatic t_baud();
        host.wr(8'h00, 8'h30);
        wait_cyc(1);
        chk_word(baud, 17'h00300, "low only");
        host.wr(8'h01, 8'h00);
        wait_cyc(1);
        chk_word(baud, 17'h00040, "divisor");
        host.wr(8'h00, 8'hFF);
        host.wr(8'h01, 8'hFF);
        wait_cyc(1);
        chk_word(baud, 17'h1000F, "max divisor");
    endtask

    task automatic t_misc();
        host.wr(8'h06, 8'hA4);
        host.wr(8'h07, 8'h07);
        host.wr(8'h08, 8'h03);
        wait_cyc(1);
        chk_byte(own, 8'hA4, "own addr");
        chk_byte(scll, 8'h07, "scl low");
        chk_byte(sclh, 8'h03, "scl high");
        host.wr(8'h08, 8'h02);
        wait_cyc(1);
        chk_byte({sclh[3:0], scll[3:0]}, 8'h55, "scl floor");
        rd_chk(8'h08, 8'h02, "scl readback");
        host.wr(8'h05, 8'h3C);
        host.wr(8'h0A, 8'h3C);
        rd_chk(8'h05, 8'h00, "reserved");
        rd_chk(8'h0A, 8'hF0, "status");
    endtask

    task automatic watch(input int n, input logic stepping, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            step = stepping && (i % 4 == 0);
            if (mrst === 1'b1)
                seen = 1'b1;
        end
        step = 1'b0;
    endtask

    task automatic t_tmo();
        int n = 0;
        logic seen;
        host.wr(8'h09, 8'h05);
        act = 1'b1;
        scl = 1'b0;
        while (mrst !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        scl = 1'b1;
        chk_bit(n >= 2*TICK && n <= 2*TICK+6, 1'b1, "tmo");
        wait_cyc(1);
        chk_bit(mrst, 1'b0, "pulse length");
        rd_chk(8'h0A, 8'hF8, "timeout code");
        scl = 1'b0;
        watch(40, 1'b1, seen);
        chk_bit(seen, 1'b0, "step reload");
        host.wr(8'h09, 8'h04);
        watch(30, 1'b0, seen);
        chk_bit(seen, 1'b0, "disabled");
        scl = 1'b1;
        act = 1'b0;
    endtask

    task automatic t_frame();
        logic [3:0] codes [0:2] = '{4'h1, 4'h2, 4'h0};
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk);
            fcode = codes[i];
            fdone = 1'b1;
            @(negedge ref_clk);
            fdone = 1'b0;
            rd_chk(8'h0A, {4'hF, codes[i]}, "frame code");
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run needs about three hundred cycles; the ceiling leaves margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail("run hung");
            stop_test();
        end
    end

    initial begin
        wait_cyc(20);
        resetn = 1'b1;
        wait_cyc(3);
        t_reset();
        t_level();
        t_modes();
        t_fields();
        t_baud();
        t_misc();
        t_tmo();
        t_frame();
        stop_test();
    end
endmodule

/* File: verification/ucb_host_model.sv */
/*
 Host-side model of the register command port: issues the write and
 read strobes that a W or R command frame turns into.
 Assumes a free-running clk; strobes change on its falling edge.
*/
`timescale 1ns/1ps
module ucb_host_model (
    input wire logic clk, // Reference clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Register address
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic reg_rvalid // Read data valid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
    end

    // One address-data pair of a write frame
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // Inverted leftovers so a stale address is never mistaken as live
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask

    // One address of a read frame; contents come a cycle later
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic ok);
        @(negedge clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        ok = reg_rvalid;
        data = reg_rdata;
    endtask
endmodule
